// File: common/sdec_map.svh
// register map, field positions, reset values and reason codes of the drop-event capture block
// assumes inclusion by the design files and the bench that decode the register word
`ifndef SDEC_MAP_SVH
`define SDEC_MAP_SVH

// ----------------------------------------
// register indices; byte address is index times four
// ----------------------------------------
`define SDEC_IDX_MASK 16'h1880
`define SDEC_IDX_STATUS 16'h1881
`define SDEC_IDX_LSB 2
`define SDEC_IDX_MSB 17

// ----------------------------------------
// status word fields
// ----------------------------------------
`define SDEC_PEND_BIT 0
`define SDEC_A_VALID_BIT 1
`define SDEC_A_PORT_LSB 2
`define SDEC_A_REASON_LSB 4
`define SDEC_B_VALID_BIT 8
`define SDEC_B_PORT_LSB 9
`define SDEC_B_REASON_LSB 11

// ----------------------------------------
// mask word field and reset value
// ----------------------------------------
`define SDEC_MASK_BIT 0
`define SDEC_MASK_RST 1'b1

// ----------------------------------------
// ports and drop reasons
// ----------------------------------------
`define SDEC_PORT_RSVD 2'h3
`define SDEC_RSN_TAG_ONLY 4'h0
`define SDEC_RSN_UNK_NOT_MEMBER 4'h1
`define SDEC_RSN_SRC_NOT_FWD 4'h2
`define SDEC_RSN_DST_NOT_FWD 4'h3
`define SDEC_RSN_DST_NOT_MEMBER 4'h4
`define SDEC_RSN_SRC_NOT_MEMBER 4'h5
`define SDEC_RSN_UNK_UNICAST 4'h6
`define SDEC_RSN_UNK_MULTICAST 4'h7
`define SDEC_RSN_BCAST_THROTTLE 4'h8
`define SDEC_RSN_UNK_SRC_NOT_FWD 4'h9
`define SDEC_RSN_SAME_PORT 4'ha
`define SDEC_RSN_FILTERED 4'hb
`define SDEC_RSN_RSVD_C 4'hc
`define SDEC_RSN_RSVD_D 4'hd
`define SDEC_RSN_VID_ALL_ONES 4'he
`define SDEC_RSN_RSVD_F 4'hf

`endif

// File: common/sdec_pkg.sv
// types shared by the drop-event capture block
// assumes the map header is on the include path
`default_nettype none

package sdec_pkg;
	// ----------------------------------------
	// drop causes reported by forwarding logic
	// ----------------------------------------
	typedef struct packed {
		logic vlan_all_ones;
		logic tagged_only_admission;
		logic untagged;
		logic dst_known;
		logic dst_unicast;
		logic dst_multicast;
		logic dst_broadcast;
		logic member_check;
		logic admit_non_member;
		logic src_member;
		logic dst_member;
		logic src_forwarding;
		logic dst_forwarding;
		logic drop_unknown;
		logic filter_multicast;
		logic bcast_throttled;
		logic same_port;
		logic filter_flag;
	} sdec_cause_s;

	typedef struct packed {
		logic valid;
		logic [1:0] src_port;
		sdec_cause_s cause;
	} sdec_drop_s;

	typedef struct packed {
		logic [3:0] reason;
		logic [1:0] port;
		logic valid;
	} sdec_slot_s;

	typedef enum {SDEC_IDLE, SDEC_DATA} sdec_bus_e;
endpackage : sdec_pkg

`default_nettype wire

// File: logic/sdec_reason_enc.sv
// drop-reason encoder: turns the cause flags of one drop into a four-bit reason
// assumes flags come from forwarding logic on the same clock, combinational here
`timescale 1ns/1ps
`default_nettype none
`include "sdec_map.svh"

module sdec_reason_enc
	import sdec_pkg::*;
(
	input wire sdec_cause_s cause,
	output logic [3:0] reason,
	output logic known
);
	// ----------------------------------------
	// priority chain; reserved codes are never produced
	// ----------------------------------------
	always_comb begin
		reason = `SDEC_RSN_TAG_ONLY;
		known = 1'b1;
		if (cause.vlan_all_ones) begin
			reason = `SDEC_RSN_VID_ALL_ONES;
		end else if (cause.tagged_only_admission && cause.untagged) begin
			reason = `SDEC_RSN_TAG_ONLY;
		end else if (!cause.dst_known) begin
			if (!cause.src_forwarding) begin
				reason = `SDEC_RSN_UNK_SRC_NOT_FWD;
			end else if (cause.member_check && !cause.admit_non_member && !cause.src_member) begin
				reason = `SDEC_RSN_UNK_NOT_MEMBER;
			end else if (cause.dst_broadcast && cause.bcast_throttled) begin
				reason = `SDEC_RSN_BCAST_THROTTLE;
			end else if (cause.drop_unknown && cause.dst_unicast) begin
				reason = `SDEC_RSN_UNK_UNICAST;
			end else if (cause.filter_multicast && cause.dst_multicast) begin
				reason = `SDEC_RSN_UNK_MULTICAST;
			end else begin
				known = 1'b0;
			end
		end else if (!cause.src_forwarding) begin
			reason = `SDEC_RSN_SRC_NOT_FWD;
		end else if (!cause.dst_forwarding) begin
			reason = `SDEC_RSN_DST_NOT_FWD;
		end else if (cause.same_port) begin
			reason = `SDEC_RSN_SAME_PORT;
		end else if (cause.member_check && !cause.dst_member) begin
			reason = `SDEC_RSN_DST_NOT_MEMBER;
		end else if (cause.member_check && !cause.admit_non_member && !cause.src_member) begin
			reason = `SDEC_RSN_SRC_NOT_MEMBER;
		end else if (cause.filter_flag) begin
			reason = `SDEC_RSN_FILTERED;
		end else begin
			known = 1'b0;
		end
	end
endmodule : sdec_reason_enc

`default_nettype wire

// File: logic/sdec_top.sv
// drop-event capture register bank: two capture slots, read-to-clear status, interrupt mask
// assumes AHB-Lite single word transfers and drop reports on hclk from forwarding logic
`timescale 1ns/1ps
`default_nettype none
`include "sdec_map.svh"

// Contract
// - two capture slots, A filled first, B only while A holds
// - pending bit 0 set on any drop
// - slot A valid bit 1 marks bits 7:2
// - slot B valid bit 8 marks bits 14:9
// - source port fields; code 11 never reported
// - reason A bits 7:4, B bits 14:11
// - read clears all; reset zero; 31:15 reserved
// - mask blocks interrupt output
// - mask leaves status; resets masked
// - 0000: tagged-only admission, untagged frame
// - 0001: unknown dest, source not member
// - 0010/0011: source/destination not forwarding
// - 0100/0101: destination/source not member
// - 0110/0111: unknown unicast / multicast filtered
// - 1000: broadcast throttling limit exceeded
// - 1001: unknown dest, source not forwarding
// - 1010 same port, 1011 filter flag
// - 1110 all-ones VLAN; reserved codes unused
module sdec_top
	import sdec_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire sdec_drop_s drop_in,
	output logic drop_irq
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic reg_hit(input logic [31:0] addr, input logic [15:0] idx);
		reg_hit = (addr[`SDEC_IDX_MSB:`SDEC_IDX_LSB] == idx) && (addr[31:`SDEC_IDX_MSB+1] == 14'h0000);
	endfunction : reg_hit

	function automatic logic [31:0] pack_status(input logic pend, input sdec_slot_s a, input sdec_slot_s b);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`SDEC_PEND_BIT] = pend;
		w[`SDEC_A_VALID_BIT] = a.valid;
		w[`SDEC_A_PORT_LSB +: 2] = a.port;
		w[`SDEC_A_REASON_LSB +: 4] = a.reason;
		w[`SDEC_B_VALID_BIT] = b.valid;
		w[`SDEC_B_PORT_LSB +: 2] = b.port;
		w[`SDEC_B_REASON_LSB +: 4] = b.reason;
		pack_status = w;
	endfunction : pack_status

	// ----------------------------------------
	// bus slave state
	// ----------------------------------------
	sdec_bus_e state_r;
	logic wr_q_r;
	logic [31:0] addr_q_r;
	logic mask_r;
	logic pending_r;
	sdec_slot_s slot_a_r;
	sdec_slot_s slot_b_r;
	logic [3:0] enc_reason;
	logic enc_known;
	logic req;
	logic data_done;
	logic rd_clr;
	logic ev_ok;
	sdec_slot_s base_a;
	sdec_slot_s base_b;

	// one wait state so read data comes straight from a flop
	assign req = hsel && hready && htrans[1];
	assign data_done = (state_r == SDEC_DATA);
	assign rd_clr = data_done && !wr_q_r && reg_hit(addr_q_r, `SDEC_IDX_STATUS);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= SDEC_IDLE;
		end else begin
			unique case (state_r)
				SDEC_IDLE: begin
					if (req) begin
						state_r <= SDEC_DATA;
					end
				end
				SDEC_DATA: begin
					state_r <= SDEC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q_r <= 1'b0;
			addr_q_r <= 32'h0000_0000;
		end else if (state_r == SDEC_IDLE && req) begin
			wr_q_r <= hwrite;
			addr_q_r <= haddr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
		end else if (state_r == SDEC_IDLE && req) begin
			hreadyout <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
		end
	end

	// only whole words are expected; hsize is accepted as is
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// unmapped addresses read as zero and ignore writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (data_done && !wr_q_r) begin
			if (reg_hit(addr_q_r, `SDEC_IDX_STATUS)) begin
				hrdata <= pack_status(pending_r, slot_a_r, slot_b_r);
			end else if (reg_hit(addr_q_r, `SDEC_IDX_MASK)) begin
				hrdata <= {31'h0000_0000, mask_r};
			end else begin
				hrdata <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------
	// mask register
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_r <= `SDEC_MASK_RST;
		end else if (data_done && wr_q_r && reg_hit(addr_q_r, `SDEC_IDX_MASK)) begin
			mask_r <= hwdata[`SDEC_MASK_BIT];
		end
	end

	// ----------------------------------------
	// drop capture
	// ----------------------------------------
	sdec_reason_enc u_enc (
		.cause(drop_in.cause),
		.reason(enc_reason),
		.known(enc_known)
	);

	// a drop without a known reason or on the reserved port only raises pending
	assign ev_ok = drop_in.valid && enc_known && (drop_in.src_port != `SDEC_PORT_RSVD);

	// the clear is applied first so a drop in the read cycle survives it
	always_comb begin
		base_a = rd_clr ? '0 : slot_a_r;
		base_b = rd_clr ? '0 : slot_b_r;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pending_r <= 1'b0;
		end else begin
			pending_r <= (pending_r && !rd_clr) || drop_in.valid;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slot_a_r <= '0;
		end else if (ev_ok && !base_a.valid) begin
			slot_a_r <= '{reason: enc_reason, port: drop_in.src_port, valid: 1'b1};
		end else begin
			slot_a_r <= base_a;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slot_b_r <= '0;
		end else if (ev_ok && base_a.valid && !base_b.valid) begin
			slot_b_r <= '{reason: enc_reason, port: drop_in.src_port, valid: 1'b1};
		end else begin
			slot_b_r <= base_b;
		end
	end

	// ----------------------------------------
	// interrupt request
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drop_irq <= 1'b0;
		end else begin
			drop_irq <= pending_r && !mask_r;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_addr_phase;
		state_r == SDEC_IDLE && req;
	endsequence

	sequence s_data_phase;
		!hreadyout ##1 hreadyout;
	endsequence

	property p_bus_wait;
		@(posedge hclk) disable iff (!hresetn)
		s_addr_phase |=> s_data_phase;
	endproperty
	a_bus_wait: assert property (p_bus_wait) else $error("data phase not one wait state");

	property p_pending_set;
		@(posedge hclk) disable iff (!hresetn)
		drop_in.valid |=> pending_r;
	endproperty
	a_pending_set: assert property (p_pending_set) else $error("drop did not set pending");

	property p_fill_a;
		@(posedge hclk) disable iff (!hresetn)
		ev_ok && !slot_a_r.valid |=> slot_a_r.valid && slot_a_r.port == $past(drop_in.src_port)
			&& slot_a_r.reason == $past(enc_reason);
	endproperty
	a_fill_a: assert property (p_fill_a) else $error("first drop not captured in slot a");

	property p_fill_b;
		@(posedge hclk) disable iff (!hresetn)
		ev_ok && slot_a_r.valid && !slot_b_r.valid && !rd_clr |=> slot_b_r.valid
			&& $stable(slot_a_r) && slot_b_r.port == $past(drop_in.src_port);
	endproperty
	a_fill_b: assert property (p_fill_b) else $error("second drop not captured in slot b");

	property p_full_hold;
		@(posedge hclk) disable iff (!hresetn)
		slot_a_r.valid && slot_b_r.valid && !rd_clr |=> $stable(slot_a_r) && $stable(slot_b_r);
	endproperty
	a_full_hold: assert property (p_full_hold) else $error("full slots overwritten");

	property p_no_rsvd_port;
		@(posedge hclk) disable iff (!hresetn)
		!(slot_a_r.valid && slot_a_r.port == `SDEC_PORT_RSVD) && !(slot_b_r.valid && slot_b_r.port == `SDEC_PORT_RSVD);
	endproperty
	a_no_rsvd_port: assert property (p_no_rsvd_port) else $error("reserved port captured");

	property p_read_clear;
		@(posedge hclk) disable iff (!hresetn)
		rd_clr && !drop_in.valid |=> !pending_r && !slot_a_r.valid && !slot_b_r.valid && slot_a_r.reason == 4'h0
			&& hrdata == pack_status($past(pending_r), $past(slot_a_r), $past(slot_b_r));
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read did not clear status");

	property p_irq;
		@(posedge hclk) disable iff (!hresetn)
		##1 drop_irq == ($past(pending_r) && !$past(mask_r));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not pending and unmasked");

	property p_mask_block;
		@(posedge hclk) disable iff (!hresetn)
		mask_r [*2] |-> !drop_irq;
	endproperty
	a_mask_block: assert property (p_mask_block) else $error("masked interrupt reached output");

	property p_mask_indep;
		@(posedge hclk) disable iff (!hresetn)
		data_done && wr_q_r && !drop_in.valid |=> $stable(pending_r) && $stable(slot_a_r) && $stable(slot_b_r);
	endproperty
	a_mask_indep: assert property (p_mask_indep) else $error("mask write changed status");

	property p_tag_only;
		@(posedge hclk) disable iff (!hresetn)
		ev_ok && !slot_a_r.valid && !drop_in.cause.vlan_all_ones && drop_in.cause.tagged_only_admission
			&& drop_in.cause.untagged |=> slot_a_r.reason == `SDEC_RSN_TAG_ONLY;
	endproperty
	a_tag_only: assert property (p_tag_only) else $error("tagged-only drop misreported");

	property p_no_rsvd_reason;
		@(posedge hclk) disable iff (!hresetn)
		slot_a_r.valid |-> slot_a_r.reason != `SDEC_RSN_RSVD_C && slot_a_r.reason != `SDEC_RSN_RSVD_D
			&& slot_a_r.reason != `SDEC_RSN_RSVD_F;
	endproperty
	a_no_rsvd_reason: assert property (p_no_rsvd_reason) else $error("reserved reason captured");

	property p_reserved_zero;
		@(posedge hclk) disable iff (!hresetn)
		data_done && !wr_q_r |=> hrdata[31:15] == 17'h00000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");
endmodule : sdec_top

`default_nettype wire

// File: test/sdec_drop_src.sv
// forwarding-side model: turns a requested reason code into the matching drop cause flags
// assumes requests from the bench on hclk and one drop pulse per requested cycle
`timescale 1ns/1ps
`default_nettype none

module sdec_drop_src
	import sdec_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic req,
	input wire logic [1:0] req_port,
	input wire logic [3:0] req_code,
	input wire logic req_nomatch,
	output var sdec_drop_s drop_in
);
	// ----------------------------------------
	// cause flags
	// ----------------------------------------
	// base case is a known unicast that passes every check, so nomatch gives no reason
	function automatic sdec_cause_s mk(input logic [3:0] c, input logic nm);
		sdec_cause_s k;
		k = '0;
		k.dst_known = 1'b1;
		k.dst_unicast = 1'b1;
		k.src_member = 1'b1;
		k.dst_member = 1'b1;
		k.admit_non_member = 1'b1;
		k.src_forwarding = 1'b1;
		k.dst_forwarding = 1'b1;
		if (!nm) begin
			if (c == 4'h1 || c == 4'h7 || c == 4'h8) begin
				k.dst_unicast = 1'b0;
			end
			if (c == 4'h1 || c == 4'h6 || c == 4'h7 || c == 4'h8 || c == 4'h9) begin
				k.dst_known = 1'b0;
			end
			if (c == 4'h1 || c == 4'h4 || c == 4'h5) begin
				k.member_check = 1'b1;
			end
			if (c == 4'h1 || c == 4'h5) begin
				k.admit_non_member = 1'b0;
				k.src_member = 1'b0;
			end
			k.tagged_only_admission = (c == 4'h0);
			k.untagged = (c == 4'h0);
			k.dst_broadcast = (c == 4'h1 || c == 4'h8);
			k.src_forwarding = !(c == 4'h2 || c == 4'h9);
			k.dst_forwarding = (c != 4'h3);
			k.dst_member = (c != 4'h4);
			k.drop_unknown = (c == 4'h6);
			k.dst_multicast = (c == 4'h7);
			k.filter_multicast = (c == 4'h7);
			k.bcast_throttled = (c == 4'h8);
			k.same_port = (c == 4'ha);
			k.filter_flag = (c == 4'hb);
			k.vlan_all_ones = (c == 4'he);
		end
		return k;
	endfunction : mk

	// idle lines toggle so a stale cause never looks like a fresh one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drop_in <= '0;
		end else if (req) begin
			drop_in <= '{1'b1, req_port, mk(req_code, req_nomatch)};
		end else begin
			drop_in <= '{1'b0, ~drop_in.src_port, ~drop_in.cause};
		end
	end
endmodule : sdec_drop_src

`default_nettype wire

// File: test/sdec_top_tb_top.sv
// self-checking bench of the drop-event capture bank
// assumes the design's one wait state bus and the forwarding model in sdec_drop_src
`timescale 1ns/1ps
`default_nettype none
`include "sdec_map.svh"

module sdec_top_tb_top
	import sdec_pkg::*;
();
	localparam logic [31:0] a_mask = {14'h0, `SDEC_IDX_MASK, 2'h0};
	localparam logic [31:0] a_stat = {14'h0, `SDEC_IDX_STATUS, 2'h0};
	logic hclk, hresetn, hsel, hwrite, hresp, hreadyout, drop_irq;
	logic req, req_nomatch;
	logic [1:0] htrans, req_port;
	logic [2:0] hsize;
	logic [3:0] req_code;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	logic [31:0] seed = 32'h0000ccc6;
	wire logic hready;
	sdec_drop_s drop_in;
	sdec_slot_s ea, eb;
	logic ep;
	int n_mismatch, num_checks, cyc;

	assign hready = hreadyout;
	sdec_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .drop_in(drop_in), .drop_irq(drop_irq));
	sdec_drop_src i_src (.hclk(hclk), .hresetn(hresetn), .req(req), .req_port(req_port),
		.req_code(req_code), .req_nomatch(req_nomatch), .drop_in(drop_in));

	always #20 hclk = ~hclk;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [3:0] rcode();
		logic [3:0] v;
		v = 4'(rnd() % 13);
		return (v < 4'hc) ? v : 4'he;
	endfunction : rcode

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// ready is looked at mid-cycle, where the registered value has settled
	task automatic wait_rdy(output logic [31:0] rd);
		do @(negedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		@(posedge hclk);
	endtask : wait_rdy

	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		wait_rdy(rd);
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy(rd);
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask : ahb

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string nm);
		ahb(1'b0, a, rnd(), rdv);
		chk(nm, rdv, e);
	endtask : rd_chk

	task automatic rd_stat();
		rd_chk(a_stat, {17'h0, eb, ea, ep}, "status");
		ea = '0;
		eb = '0;
		ep = 1'b0;
	endtask : rd_stat

	// drop request stays up; quiet() lowers it so no signal is set twice in one step
	task automatic drop(input logic [1:0] p, input logic [3:0] c, input logic nm);
		req <= 1'b1;
		req_port <= p;
		req_code <= c;
		req_nomatch <= nm;
		ep = 1'b1;
		if (!nm && p != 2'h3) begin
			if (!ea.valid)
				ea = '{c, p, 1'b1};
			else if (!eb.valid)
				eb = '{c, p, 1'b1};
		end
		@(posedge hclk);
	endtask : drop

	task automatic quiet();
		req <= 1'b0;
		@(posedge hclk);
		@(posedge hclk);
	endtask : quiet

	task automatic look_irq(input logic e);
		@(negedge hclk);
		chk("irq", {31'h0, drop_irq}, {31'h0, e});
		@(posedge hclk);
	endtask : look_irq

	always @(posedge hclk) begin
		cyc++;
		if (cyc == 8000) begin
			n_mismatch++;
			end_sim();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int k;
		hclk = 1'b0;
		hresetn = 1'b0;
		{hsel, hwrite, req, req_nomatch, htrans, req_port, req_code} = '0;
		hsize = 3'h2;
		haddr = '0;
		hwdata = '0;
		{ea, eb, ep} = '0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		look_irq(1'b0);
		rd_chk(a_mask, 32'h1, "mask reset");
		rd_chk(a_stat, 32'h0, "status reset");
		ahb(1'b1, a_stat, 32'hffffffff, rdv);
		ahb(1'b1, 32'h00006208, 32'h00000001, rdv);
		rd_chk(32'h00006208, 32'h0, "unmapped");
		rd_chk(a_stat, 32'h0, "status after write");
		// masked drop: no interrupt, status still recorded
		drop(2'h1, 4'h3, 1'b0);
		quiet();
		look_irq(1'b0);
		rd_stat();
		ahb(1'b1, a_mask, 32'h0, rdv);
		rd_chk(a_mask, 32'h0, "mask");
		drop(2'h2, 4'he, 1'b0);
		quiet();
		look_irq(1'b1);
		rd_stat();
		look_irq(1'b0);
		// reset in mid-run brings back a cleared status and the masked state
		drop(2'h0, 4'h5, 1'b0);
		quiet();
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		{ea, eb, ep} = '0;
		@(posedge hclk);
		look_irq(1'b0);
		rd_chk(a_mask, 32'h1, "mask after reset");
		rd_chk(a_stat, 32'h0, "status after reset");
		// reserved port and no-reason drops give pending only
		drop(2'h3, 4'h2, 1'b0);
		drop(2'h1, 4'h0, 1'b1);
		quiet();
		rd_stat();
		// drops around a status read: the one on the clearing edge starts a fresh slot a
		drop(2'h1, 4'h6, 1'b0);
		quiet();
		req <= 1'b1;
		req_code <= 4'ha;
		rd_stat();
		quiet();
		ea = '{4'ha, 2'h1, 1'b1};
		eb = ea;
		ep = 1'b1;
		rd_stat();
		for (k = 0; k < 13; k++) begin
			drop(2'(rnd() % 3), (k < 12) ? 4'(k) : 4'he, 1'b0);
			drop(2'(rnd() % 3), rcode(), 1'b0);
			drop(2'(rnd() % 3), rcode(), 1'b0);
			quiet();
			rd_stat();
			rd_chk(a_stat, 32'h0, "status cleared");
		end
		repeat (40) begin
			repeat (rnd() % 4) drop(2'(rnd() % 4), rcode(), (rnd() % 5) == 0);
			quiet();
			rd_stat();
		end
		end_sim();
	end
endmodule : sdec_top_tb_top

`default_nettype wire
